// ### src/frtid_device.sv
`timescale 1ns/1ps
// What this block does
// RQ1: Reset pair clears all state to defaults
// RQ2: Reset-enable opcode shifted MSB first on io0
// RQ3: Host releases select one clock between opcodes
// RQ4: Reset only for back-to-back enable, reset pair
// RQ5: Start reset after release; refuse commands meanwhile
// RQ6: Select release off byte boundary abandons command
// RQ7: Host checks busy and suspend clear first; frtid_host has no busy or suspend input and checks neither
// RQ8: Terminate aborts program or erase to idle
// RQ9: Terminate ignores write-enable latch bit
// RQ10: Terminate needs reset-enabled bit in register five
// RQ11: Wrong confirmation byte ignores whole terminate
// RQ12: Start terminate after release; refuse commands meanwhile
// RQ13: Aborted page contents are not guaranteed
// RQ14: Terminate keeps volatile configuration unchanged
// RQ15: Terminate released off byte boundary goes standby
// RQ16: Single-line ID takes three ignored dummy bytes
// RQ17: Maker then part code, MSB first, io1
// RQ18: Codes repeat while selected; release floats io1
// RQ19: Quad ID: opcode single, address four lines
// RQ20: Mode byte two clocks, then four dummy clocks
// RQ21: Quad byte over two clocks, nibbles on io3..io0
// RQ22: Quad output repeats maker and part codes
// RQ23: Host releases before output; device releases at select
module frtid_device
  import frtid_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = frtid_pkg::MAKER_CODE_DEF,
  parameter logic [7:0] PART_CODE  = frtid_pkg::PART_CODE_DEF
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Link
  frtid_if.device   link,
  // Core status and controls
  input  wire logic busy_flag,
  input  wire logic suspended_operation_flag,
  input  wire logic write_enable_latch_bit,
  output logic      abort_pulse,
  output logic      reset_pulse,
  output logic      reset_enabled_bit,
  output logic      cmd_busy
);
  import frtid_pkg::*;

  logic [5:0] s_sync;
  logic       cs_n_s;
  logic       sck_s;
  logic [3:0] io_s;
  logic       sck_d_reg;
  logic       cs_d_reg;
  logic       rise;
  logic       fall;
  logic       cs_rise;
  logic [5:0] cnt_reg;
  logic [7:0] opc_reg;
  logic [7:0] dat_reg;
  logic       rsten_armed_reg;
  logic       busy_reg;
  logic [7:0] busy_cnt_reg;
  logic       pend_reset_reg;
  logic       pend_term_reg;
  logic [3:0] out_reg;
  logic [3:0] oe_reg;
  logic [3:0] obit_reg;
  logic       out_act;
  logic       quad;
  logic [7:0] id_cur;
  logic [7:0] start_cyc;
  logic       refuse_reg;

  frtid_sync #(.W(6)) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .d       ({~link.cs_n, link.sck, link.io_host_o}),
    .q       (s_sync)
  );
  // Select passes inverted so that the synchroniser's reset value reads as deselected
  assign cs_n_s = ~s_sync[5];
  assign sck_s  = s_sync[4];
  assign io_s   = s_sync[3:0];

  function automatic logic [7:0] id_byte(input logic sel);
    id_byte = sel ? PART_CODE : MAKER_CODE;
  endfunction

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sck_d_reg <= 1'b0;
      cs_d_reg  <= 1'b1;
    end else begin
      sck_d_reg <= sck_s;
      cs_d_reg  <= cs_n_s;
    end
  end
  assign rise    = sck_s & ~sck_d_reg & ~cs_n_s;
  assign fall    = ~sck_s & sck_d_reg & ~cs_n_s;
  assign cs_rise = cs_n_s & ~cs_d_reg;
  assign quad    = (opc_reg == OP_ID_QUAD);
  assign id_cur  = id_byte(quad ? obit_reg[1] : obit_reg[3]);

  // A frame opened while busy stays refused to its end, so its tail is never
  // decoded as a fresh command
  always_ff @(posedge sys_clk) begin
    if (rst || cs_n_s) begin
      refuse_reg <= 1'b0;
    end else if (busy_reg) begin
      refuse_reg <= 1'b1; // RQ5 RQ12
    end
  end

  // Bit counter and input shifting
  always_ff @(posedge sys_clk) begin
    if (rst || cs_n_s) begin
      cnt_reg <= '0;
      opc_reg <= '0;
      dat_reg <= '0;
    end else if (rise && !busy_reg && !refuse_reg) begin
      if (cnt_reg != 6'h3f)
        cnt_reg <= cnt_reg + 6'h01;
      if (cnt_reg < OPC_CLKS)
        opc_reg <= {opc_reg[6:0], io_s[0]}; // RQ2
      else if (cnt_reg < OPC_CLKS + OPC_CLKS)
        dat_reg <= {dat_reg[6:0], io_s[0]}; // RQ11
    end
  end

  // Command completion on select release
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rsten_armed_reg   <= 1'b0;
      reset_enabled_bit <= 1'b0;
      pend_reset_reg    <= 1'b0;
      pend_term_reg     <= 1'b0;
    end else if (reset_pulse) begin
      rsten_armed_reg   <= 1'b0; // RQ1
      reset_enabled_bit <= 1'b0; // RQ1
      pend_reset_reg    <= 1'b0;
    end else if (abort_pulse) begin
      pend_term_reg <= 1'b0; // RQ14
    end else if (cs_rise && !busy_reg && !refuse_reg) begin
      rsten_armed_reg <= 1'b0; // RQ4
      if (cnt_reg[2:0] == 3'h0 && cnt_reg != 6'h00) begin // RQ6 RQ15
        if (cnt_reg == OPC_CLKS && opc_reg == OP_RST_EN)
          rsten_armed_reg <= 1'b1;
        if (cnt_reg == OPC_CLKS && opc_reg == OP_RST && rsten_armed_reg)
          pend_reset_reg <= 1'b1; // RQ4 RQ5
        if (cnt_reg == OPC_CLKS + OPC_CLKS && opc_reg == OP_TERM
            && dat_reg == TERM_CONFIRM && reset_enabled_bit)
          pend_term_reg <= 1'b1; // RQ9 RQ10 RQ11 RQ12
        if (cnt_reg == OPC_CLKS + OPC_CLKS && opc_reg == OP_WR_SR
            && dat_reg == SR5_OFFSET)
          reset_enabled_bit <= 1'b1; // RQ10
      end
    end
  end

  // Start delay then busy window for reset or terminate
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy_reg     <= 1'b0;
      busy_cnt_reg <= '0;
      reset_pulse  <= 1'b0;
      abort_pulse  <= 1'b0;
    end else begin
      reset_pulse <= 1'b0;
      abort_pulse <= 1'b0;
      if (!busy_reg && (pend_reset_reg || pend_term_reg)) begin
        busy_reg     <= 1'b1; // RQ5 RQ12
        busy_cnt_reg <= '0;
      end else if (busy_reg) begin
        busy_cnt_reg <= busy_cnt_reg + 8'h01;
        if (busy_cnt_reg == start_cyc) begin
          reset_pulse <= pend_reset_reg; // RQ1
          abort_pulse <= pend_term_reg; // RQ8 RQ13
        end
        if (busy_cnt_reg == 8'(RESET_BUSY_CYC - 1))
          busy_reg <= 1'b0;
      end
    end
  end
  assign cmd_busy = busy_reg;
  assign start_cyc = pend_reset_reg ? 8'(RESET_START_CYC - 1) : 8'(TERM_START_CYC - 1);

  // Output phase and drivers
  assign out_act = quad ? (cnt_reg >= QID_DUMMY_END) : (cnt_reg >= SID_ADDR_END);
  always_ff @(posedge sys_clk) begin
    if (rst || cs_n_s) begin
      out_reg  <= '0;
      oe_reg   <= '0; // RQ18 RQ23
      obit_reg <= '0;
    end else if (fall && out_act && !busy_reg) begin
      if (opc_reg == OP_ID_SINGLE) begin
        out_reg  <= {2'b00, id_cur[3'h7 - obit_reg[2:0]], 1'b0}; // RQ16 RQ17
        oe_reg   <= 4'h2;
        obit_reg <= obit_reg + 4'h1; // RQ18
      end else if (quad) begin
        out_reg  <= obit_reg[0] ? id_cur[3:0]
                                : id_cur[7:4]; // RQ21
        oe_reg   <= 4'hf; // RQ19 RQ20 RQ23
        obit_reg <= {2'b00, obit_reg[1:0] + 2'h1}; // RQ22
      end
    end
  end
  assign link.io_dev_o  = out_reg;
  assign link.io_dev_oe = oe_reg;
endmodule

// ### src/frtid_host.sv
`timescale 1ns/1ps
module frtid_host
  import frtid_pkg::*;
(
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // Link
  frtid_if.host                     link,
  // Command request
  input  wire logic                 req_valid,
  input  wire frtid_pkg::frtid_cmd_e req_cmd,
  output logic                      req_ready,
  // Answer
  output logic                      rsp_valid,
  output logic [7:0]                rsp_maker,
  output logic [7:0]                rsp_part
);
  import frtid_pkg::*;

  typedef enum {S_IDLE, S_SHIFT, S_GAP} frtid_state_e;
  frtid_state_e state_reg;
  frtid_cmd_e   cmd_reg;
  logic [3:0]   div_reg;
  logic [5:0]   clk_cnt_reg;
  logic [5:0]   last_reg;
  logic         second_reg;
  logic         sck_reg;
  logic [15:0]  rx_reg;
  logic [7:0]   cur_byte;
  logic [3:0]   in_s;
  logic         quad;

  frtid_sync #(.W(4)) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .d       (link.io_dev_o),
    .q       (in_s)
  );
  assign quad = (cmd_reg == FRTID_CMD_ID4);

  function automatic logic [7:0] opcode(input frtid_cmd_e c, input logic second);
    case (c)
      FRTID_CMD_RESET: opcode = second ? OP_RST : OP_RST_EN;
      FRTID_CMD_TERM:  opcode = OP_TERM;
      FRTID_CMD_ID1:   opcode = OP_ID_SINGLE;
      default:         opcode = OP_ID_QUAD;
    endcase
  endfunction

  // Confirmation byte follows the terminate opcode
  assign cur_byte = (clk_cnt_reg < OPC_CLKS) ? opcode(cmd_reg, second_reg) : TERM_CONFIRM;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg   <= S_IDLE;
      cmd_reg     <= FRTID_CMD_RESET;
      div_reg     <= '0;
      clk_cnt_reg <= '0;
      last_reg    <= '0;
      second_reg  <= 1'b0;
      sck_reg     <= 1'b0;
      rx_reg      <= '0;
      rsp_valid   <= 1'b0;
      rsp_maker   <= '0;
      rsp_part    <= '0;
    end else begin
      rsp_valid <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (req_valid) begin
            cmd_reg     <= req_cmd;
            second_reg  <= 1'b0;
            clk_cnt_reg <= '0;
            div_reg     <= '0;
            state_reg   <= S_SHIFT;
            case (req_cmd)
              FRTID_CMD_RESET: last_reg <= OPC_CLKS;
              FRTID_CMD_TERM:  last_reg <= OPC_CLKS + OPC_CLKS;
              FRTID_CMD_ID1:   last_reg <= SID_ADDR_END + 6'h10;
              default:         last_reg <= QID_DUMMY_END + 6'h04;
            endcase
          end
        end
        S_SHIFT: begin
          div_reg <= div_reg + 4'h1;
          if (div_reg == SCK_HALF_CYC - 4'h1) begin
            div_reg <= '0;
            sck_reg <= ~sck_reg;
            if (sck_reg) begin
              clk_cnt_reg <= clk_cnt_reg + 6'h01;
              if (clk_cnt_reg + 6'h01 == last_reg) begin
                state_reg <= S_GAP;
              end
              // Device data lags the pin by its synchroniser and ours, so it is
              // taken at the falling edge that closes the clock it belongs to
              if (quad ? clk_cnt_reg >= QID_DUMMY_END : clk_cnt_reg >= SID_ADDR_END) begin
                rx_reg <= quad ? {rx_reg[11:0], in_s} : {rx_reg[14:0], in_s[1]};
              end
            end
          end
        end
        S_GAP: begin
          div_reg <= div_reg + 4'h1;
          if (div_reg == CS_GAP_CYC - 4'h1) begin // RQ3
            div_reg     <= '0;
            clk_cnt_reg <= '0;
            if (cmd_reg == FRTID_CMD_RESET && !second_reg) begin
              second_reg <= 1'b1; // RQ4
              state_reg  <= S_SHIFT;
            end else begin
              state_reg <= S_IDLE;
              rsp_valid <= 1'b1;
              rsp_maker <= rx_reg[15:8];
              rsp_part  <= rx_reg[7:0];
            end
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  assign req_ready      = (state_reg == S_IDLE);
  assign link.cs_n      = (state_reg != S_SHIFT);
  assign link.sck       = sck_reg;
  // Opcode and confirmation go out MSB first on io0
  assign link.io_host_o = {3'b000, cur_byte[3'h7 - clk_cnt_reg[2:0]]}; // RQ2 RQ11
  // Quad dummy address and mode drive zero on io3..io1 and the confirmation byte bits on io0
  assign link.io_host_oe = (state_reg != S_SHIFT) ? 4'h0 :
                           (clk_cnt_reg < OPC_CLKS) ? 4'h1 :
                           (quad && clk_cnt_reg < QID_MODE_END) ? 4'hf : // RQ19 RQ20
                           (quad) ? 4'h0 : // RQ23
                           (clk_cnt_reg < SID_ADDR_END && cmd_reg == FRTID_CMD_ID1) ? 4'h1 :
                           (cmd_reg == FRTID_CMD_TERM) ? 4'h1 : 4'h0; // RQ16
endmodule

// ### src/frtid_if.sv
`timescale 1ns/1ps
interface frtid_if;
  logic       cs_n;
  logic       sck;
  logic [3:0] io_host_o;
  logic [3:0] io_host_oe;
  logic [3:0] io_dev_o;
  logic [3:0] io_dev_oe;
  modport device (
    input  cs_n,
    input  sck,
    input  io_host_o,
    input  io_host_oe,
    output io_dev_o,
    output io_dev_oe
  );
  modport host (
    output cs_n,
    output sck,
    output io_host_o,
    output io_host_oe,
    input  io_dev_o,
    input  io_dev_oe
  );
endinterface

// ### src/frtid_pkg.sv
package frtid_pkg;
  // Opcodes and confirmation byte
  localparam logic [7:0] OP_RST_EN   = 8'h66;
  localparam logic [7:0] OP_RST      = 8'h99;
  localparam logic [7:0] OP_TERM     = 8'hf0;
  localparam logic [7:0] TERM_CONFIRM = 8'hd0;
  localparam logic [7:0] OP_ID_SINGLE = 8'h90;
  localparam logic [7:0] OP_ID_QUAD  = 8'h94;
  localparam logic [7:0] OP_WR_SR    = 8'h71;
  localparam logic [7:0] SR5_OFFSET  = 8'h05;
  localparam int         SR5_RESET_ENABLED_BIT_BIT = 0;
  // Identification codes, arbitrary values
  localparam logic [7:0] MAKER_CODE_DEF = 8'h5a;
  localparam logic [7:0] PART_CODE_DEF  = 8'h3c;
  // Phase boundaries in serial clocks
  localparam logic [5:0] OPC_CLKS      = 6'h08;
  localparam logic [5:0] SID_ADDR_END  = 6'h20;
  localparam logic [5:0] QID_ADDR_END  = 6'h0e;
  localparam logic [5:0] QID_MODE_END  = 6'h10;
  localparam logic [5:0] QID_DUMMY_END = 6'h14;
  // Internal timings
  localparam int SYS_CLK_PERIOD_NS        = 5;
  localparam int SOFTWARE_RESET_START_NS  = 100;
  localparam int TERMINATE_START_NS       = 100;
  localparam int RESET_BUSY_NS            = 200;
  localparam int RESET_START_CYC = SOFTWARE_RESET_START_NS / SYS_CLK_PERIOD_NS;
  localparam int TERM_START_CYC  = TERMINATE_START_NS / SYS_CLK_PERIOD_NS;
  localparam int RESET_BUSY_CYC  = RESET_BUSY_NS / SYS_CLK_PERIOD_NS;
  // Host link timing: serial clock half period and select gap, in sys_clk cycles
  localparam logic [3:0] SCK_HALF_CYC = 4'h4;
  localparam logic [3:0] CS_GAP_CYC   = 4'h8;
  typedef enum logic [1:0] {FRTID_CMD_RESET, FRTID_CMD_TERM, FRTID_CMD_ID1,
                            FRTID_CMD_ID4} frtid_cmd_e;
endpackage

// ### src/frtid_sync.sv
`timescale 1ns/1ps
module frtid_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// ### verification/frtid_assertions.sv
`timescale 1ns/1ps
module frtid_assertions (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  // Link
  input wire logic       cs_n,
  input wire logic       sck,
  input wire logic [3:0] io_host_oe,
  input wire logic [3:0] io_dev_oe,
  // Device status
  input wire logic       reset_pulse,
  input wire logic       abort_pulse,
  input wire logic       reset_enabled_bit,
  input wire logic       cmd_busy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  dev_release_a: assert property (cs_n [*5] |-> io_dev_oe == 4'h0)
    else $error("device drives after select release");
  no_contention_a: assert property ((io_dev_oe & io_host_oe) == 4'h0)
    else $error("both ends drive one line");
  out_lanes_a: assert property (io_dev_oe != 4'h0 |-> io_dev_oe inside {4'h2, 4'hf})
    else $error("device drives a wrong set of lines");
  sck_idle_a: assert property (cs_n [*2] |-> !sck)
    else $error("serial clock moves outside a frame");
  reset_single_a: assert property (reset_pulse |=> !reset_pulse [*8])
    else $error("reset pulse repeats");
  reset_clears_a: assert property (reset_pulse |-> ##[0:2] !reset_enabled_bit)
    else $error("reset leaves enable bit set");
  abort_enabled_a: assert property (
    abort_pulse |-> reset_enabled_bit ##1 (reset_enabled_bit && !abort_pulse))
    else $error("abort without enable bit or enable bit lost");
  busy_quiet_a: assert property (cmd_busy |-> io_dev_oe == 4'h0)
    else $error("device answers while busy");
  cover property (reset_pulse);
  cover property (io_dev_oe == 4'hf);
  cover property (io_dev_oe == 4'h2);
  cover property (abort_pulse);
endmodule

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
  import frtid_pkg::*;
  // Arbitrary identification values
  localparam logic [7:0] MAKER = 8'ha7;
  localparam logic [7:0] PART  = 8'h3e;
  logic        sys_clk;
  logic        rst;
  logic        req_valid;
  frtid_cmd_e  req_cmd;
  logic        req_ready;
  logic        rsp_valid;
  logic [7:0]  rsp_maker;
  logic [7:0]  rsp_part;
  logic        busy_flag;
  logic        suspended_operation_flag_flag;
  logic        wel_bit;
  logic        abort_a, reset_a, reset_enabled_bit_a, busy_a;
  logic        abort_b, reset_b, reset_enabled_bit_b, busy_b;
  logic [3:0]  wire_a;
  logic [3:0]  wire_b;
  logic [7:0]  op_sh;
  logic [15:0] s_sh;
  logic [15:0] q_sh;
  logic [31:0] rx_b;
  int          n_clk;
  int          n_errors;
  int          samples_checked;
  int          n_abort_b;
  int          n_abort_a;
  int          n_reset_a;
  int          n_reset_b;
  frtid_if link_a ();
  frtid_if link_b ();
  frtid_host frtid_host_inst (.sys_clk(sys_clk), .rst(rst), .link(link_a.host),
    .req_valid(req_valid), .req_cmd(req_cmd), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_maker(rsp_maker), .rsp_part(rsp_part));
  frtid_device #(.MAKER_CODE(MAKER), .PART_CODE(PART)) frtid_device_inst (
    .sys_clk(sys_clk), .rst(rst), .link(link_a.device), .busy_flag(busy_flag),
    .suspended_operation_flag(suspended_operation_flag_flag), .write_enable_latch_bit(wel_bit),
    .abort_pulse(abort_a), .reset_pulse(reset_a), .reset_enabled_bit(reset_enabled_bit_a),
    .cmd_busy(busy_a));
  // Second device faces a bench driver that breaks the host's rules
  frtid_device #(.MAKER_CODE(MAKER), .PART_CODE(PART)) frtid_device_inst_b (
    .sys_clk(sys_clk), .rst(rst), .link(link_b.device), .busy_flag(busy_flag),
    .suspended_operation_flag(suspended_operation_flag_flag), .write_enable_latch_bit(wel_bit),
    .abort_pulse(abort_b), .reset_pulse(reset_b), .reset_enabled_bit(reset_enabled_bit_b),
    .cmd_busy(busy_b));
  // Pulses and enable bit come from the second device, the only one that accepts a terminate
  frtid_assertions frtid_assertions_inst (.sys_clk(sys_clk), .rst(rst),
    .cs_n(link_a.cs_n), .sck(link_a.sck), .io_host_oe(link_a.io_host_oe),
    .io_dev_oe(link_a.io_dev_oe), .reset_pulse(reset_b), .abort_pulse(abort_b),
    .reset_enabled_bit(reset_enabled_bit_b), .cmd_busy(busy_a));
  // Device wins, then host, else pull-up
  assign wire_a = (link_a.io_dev_oe & link_a.io_dev_o) | ~(link_a.io_dev_oe | link_a.io_host_oe)
                | (~link_a.io_dev_oe & link_a.io_host_oe & link_a.io_host_o);
  assign wire_b = (link_b.io_dev_oe & link_b.io_dev_o) | ~(link_b.io_dev_oe | link_b.io_host_oe)
                | (~link_b.io_dev_oe & link_b.io_host_oe & link_b.io_host_o);
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    n_reset_a <= n_reset_a + int'(reset_a === 1'b1);
    n_reset_b <= n_reset_b + int'(reset_b === 1'b1);
    n_abort_b <= n_abort_b + int'(abort_b === 1'b1);
    n_abort_a <= n_abort_a + int'(abort_a === 1'b1);
  end
  // Wire monitor of the first link, restarted at each select
  always @(posedge link_a.sck or negedge link_a.cs_n) begin
    if (!link_a.sck) begin
      n_clk <= 0;
    end else if (!link_a.cs_n) begin
      if (n_clk < 8) op_sh <= {op_sh[6:0], wire_a[0]};
      if (link_a.io_dev_oe == 4'hf) q_sh <= {q_sh[11:0], wire_a};
      else if (link_a.io_dev_oe[1]) s_sh <= {s_sh[14:0], wire_a[1]};
      n_clk <= n_clk + 1;
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results();
    $display("Checked %0d, errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cmd(input frtid_cmd_e c);
    int k;
    req_valid <= 1'b1;
    req_cmd   <= c;
    @(negedge sys_clk);
    for (k = 0; k < 100 && req_ready !== 1'b1; k++) @(negedge sys_clk);
    @(posedge sys_clk);
    req_valid <= 1'b0;
    for (k = 0; k < 4000 && rsp_valid !== 1'b1; k++) @(negedge sys_clk);
    if (k == 4000) check("answer", 0, 1);
    @(posedge sys_clk);
  endtask
  // Bit-banged frame on the second link, serial clock of 13 system clocks
  task automatic send(input logic [63:0] v, input int n);
    link_b.cs_n       <= 1'b0;
    link_b.io_host_oe <= 4'h1;
    for (int i = n - 1; i >= 0; i--) begin
      link_b.io_host_o[0] <= v[i];
      repeat (6) @(posedge sys_clk);
      link_b.sck <= 1'b1;
      rx_b = {rx_b[30:0], wire_b[1]};
      repeat (7) @(posedge sys_clk);
      link_b.sck <= 1'b0;
    end
    repeat (6) @(posedge sys_clk);
    link_b.cs_n       <= 1'b1;
    link_b.io_host_oe <= 4'h0;
    link_b.io_host_o  <= ~link_b.io_host_o;
    repeat (13) @(posedge sys_clk);
  endtask
  task automatic done(input string name);
    $display("Test %s ended, errors %0d", name, n_errors);
  endtask
  initial begin
    #300000;
    n_errors++;
    results();
  end
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_cmd = FRTID_CMD_ID1;
    {busy_flag, suspended_operation_flag_flag, wel_bit} = 3'b000;
    {link_b.cs_n, link_b.sck, link_b.io_host_o, link_b.io_host_oe} = {2'b10, 4'hf, 4'h0};
    {n_errors, samples_checked, n_abort_a, n_abort_b, n_reset_a, n_reset_b} = '0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    cmd(FRTID_CMD_ID1);
    check("id1 result", {rsp_maker, rsp_part}, {MAKER, PART});
    check("id1 wire", s_sh, {MAKER, PART});
    check("id1 clocks", n_clk, 48);
    check("id1 opcode", op_sh, OP_ID_SINGLE);
    repeat (8) @(posedge sys_clk);
    check("idle lines", wire_a, 4'hf);
    cmd(FRTID_CMD_ID4);
    check("id4 result", {rsp_maker, rsp_part}, {MAKER, PART});
    check("id4 wire", q_sh, {MAKER, PART});
    check("id4 clocks", n_clk, 24);
    check("id4 opcode", op_sh, OP_ID_QUAD);
    cmd(FRTID_CMD_TERM);
    repeat (40) @(posedge sys_clk);
    check("term opcode", op_sh, OP_TERM);
    check("term clocks", n_clk, 16);
    check("term refused", n_abort_a, 0);
    done("identification");
    cmd(FRTID_CMD_RESET);
    repeat (80) @(posedge sys_clk);
    check("reset count", n_reset_a, 1);
    check("reset opcode", op_sh, OP_RST);
    done("host reset");
    send({OP_WR_SR, SR5_OFFSET}, 16);
    check("enable set", reset_enabled_bit_b, 1);
    send({OP_TERM, 8'hc0}, 16);
    send({OP_TERM, TERM_CONFIRM} >> 1, 15);
    repeat (40) @(posedge sys_clk);
    check("bad terminate", n_abort_b, 0);
    wel_bit <= 1'b1;
    send({OP_TERM, TERM_CONFIRM}, 16);
    repeat (40) @(posedge sys_clk);
    check("terminate", n_abort_b, 1);
    check("enable kept", reset_enabled_bit_b, 1);
    send(OP_RST_EN >> 1, 7);
    send(OP_RST, 8);
    send(OP_RST_EN, 8);
    send(8'h00, 8);
    send(OP_RST, 8);
    repeat (40) @(posedge sys_clk);
    check("bad reset", n_reset_b, 0);
    send({OP_ID_SINGLE, 56'h0}, 64);
    check("id1 repeat", rx_b, {MAKER, PART, MAKER, PART});
    check("released", link_b.io_dev_oe, 4'h0);
    send(OP_RST_EN, 8);
    send(OP_RST, 8);
    repeat (80) @(posedge sys_clk);
    check("reset pair", n_reset_b, 1);
    check("enable cleared", reset_enabled_bit_b, 0);
    done("rule breaking");
    results();
  end
endmodule
